// ---- logic/rxcv_defines.svh ----
// offsets, field positions, reset values and cell layout constants for the cell validation block
`ifndef RXCV_DEFINES_SVH
`define RXCV_DEFINES_SVH

// register map (byte offsets on the plain register port)
`define RXCV_CTRL_OFS     8'h14
`define RXCV_STAT_OFS     8'h3F
`define RXCV_CTRL_RST     16'h0000

// control register field positions
`define RXCV_B_SOC_SEL    15
`define RXCV_B_RX_DIS     14
`define RXCV_B_STAT_EN    13
`define RXCV_B_HDR_ONLY   12
`define RXCV_B_CRC_DIS    11
`define RXCV_B_LEN_DIS    10
`define RXCV_B_HEC_DIS    9
`define RXCV_B_HEC_COR    8

// output format codes of each 2-bit port field
`define RXCV_FMT_48       2'h0
`define RXCV_FMT_52       2'h1
`define RXCV_FMT_53       2'h2
`define RXCV_FMT_57       2'h3
`define RXCV_PORT3        2'h3

// octet positions inside one cell buffer bank
`define RXCV_IDX_PLCP     6'h00
`define RXCV_IDX_HDR      6'h04
`define RXCV_IDX_HDR_END  6'h07
`define RXCV_IDX_HEC      6'h08
`define RXCV_IDX_PAY      6'h09
`define RXCV_IDX_LAST     6'h38

`endif

// ---- logic/rxcv_pkg.sv ----
// types shared by the cell validation block
`default_nettype none
package rxcv_pkg;

  // output sequencer states
  typedef enum logic [1:0] {RD_IDLE, RD_DATA, RD_STAT} rxcv_rd_e;

  // one validated cell waiting for or under output
  typedef struct packed {
    logic        v;
    logic [1:0]  port;
    logic        hec;
    logic        crc;
    logic        len;
    logic        corr;
    logic [4:0]  cpos;
    logic [31:0] plcp;
  } rxcv_cell_s;

  // octet walk for one output format
  typedef struct packed {
    logic [5:0] first;
    logic [5:0] last;
    logic       skip;
    logic       app;
  } rxcv_fmt_s;

  // whole state of the main module
  typedef struct packed {
    logic       rx_off;
    logic       in_act;
    logic       wbank;
    logic [5:0] widx;
    rxcv_cell_s pend;
    rxcv_cell_s cur;
    rxcv_rd_e   rst;
    logic       rbank;
    logic [5:0] ridx;
    rxcv_fmt_s  fmt;
    logic       first;
    logic       ov;
    logic [7:0] od;
    logic [1:0] oport;
    logic       fpin;
    logic       hec_evt;
    logic       crc_evt;
    logic       len_evt;
  } rxcv_st_s;

  // whole state of the register slave
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] rdata;
  } rxcv_reg_s;

endpackage
`default_nettype wire

// ---- logic/rxcv_regs.sv ----
// register slave holding the validation control word and the status readback
`timescale 1ns/100ps
`default_nettype none
`include "rxcv_defines.svh"

module rxcv_regs
  import rxcv_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] stat_in,
  output logic      [15:0] ctrl,
  output logic      [15:0] reg_rdata
);

  rxcv_reg_s q;
  rxcv_reg_s n;

  ////////////////////////////////////////////////////////////////////////////
  // write decode and one-cycle read answer; unmapped reads answer zero
  always_comb begin
    n       = q;
    n.rdata = 16'h0000;
    if (reg_wr && reg_addr == `RXCV_CTRL_OFS) begin
      n.ctrl = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        `RXCV_CTRL_OFS: n.rdata = q.ctrl;   // R15
        `RXCV_STAT_OFS: n.rdata = stat_in;
        default:        n.rdata = 16'h0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '{ctrl: `RXCV_CTRL_RST, rdata: 16'h0000};
    end else begin
      q <= n;
    end
  end

  assign ctrl      = q.ctrl;
  assign reg_rdata = q.rdata;

endmodule // rxcv_regs
`default_nettype wire

// ---- logic/rxcv_top.sv ----
// receive cell validation, discard gating and per-port output formatting
//
// Functional notes
// R1: bit 15 low: control pin shows write error; high: marks output cell start.
// R2: bit 14 set stops all validation and output after line reception.
// R3: receiver disable changes take effect only at a cell boundary.
// R4: bit 13 with port 3 in 53-octet mode: drop HEC, append status octet.
// R5: software keeps other ports off 53-octet mode while port 3 status output.
// R6: bit 12: port 3 gets only four header octets plus status octet.
// R7: bit 11 stops payload CRC discards on all ports; errors still counted.
// R8: bit 10 stops payload length discards on all ports; errors still counted.
// R9: bit 9 passes HEC-errored cells, except in UTOPIA mode.
// R10: bit 8 corrects single-bit header errors; detection always runs.
// R11: software keeps correction off for SMDS coverage or coset disabled.
// R12: bits 7-6 pick port 3 format: 48, 52, 53 or 57 octets.
// R13: same encoding for port 2 bits 5-4, port 1 3-2, port 0 1-0.
// R14: global disables act on all ports, on top of per-port disables.
// R15: control reads return last write; format changes apply at next cell.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "rxcv_defines.svh"

module rxcv_top
  import rxcv_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        cell_in_valid,
  input  wire logic        cell_in_soc,
  input  wire logic        cell_in_eoc,
  input  wire logic [7:0]  cell_in_data,
  input  wire logic [1:0]  cell_port,
  input  wire logic        hec_err,
  input  wire logic        hec_single,
  input  wire logic [4:0]  hec_bitpos,
  input  wire logic        crc_err,
  input  wire logic        len_err,
  input  wire logic [31:0] plcp_oh,
  input  wire logic        utopia_mode,
  input  wire logic [3:0]  port_crc_dis,
  input  wire logic [3:0]  port_len_dis,
  input  wire logic        fifo_full,
  output logic             fifo_valid,
  output logic      [7:0]  fifo_data,
  output logic      [1:0]  fifo_port,
  output logic             fifo_control_output_pins,
  output logic             hec_err_evt,
  output logic             crc_err_evt,
  output logic             len_err_evt
);

  ////////////////////////////////////////////////////////////////////////////
  // format decode: first octet, last octet, HEC skip and status append
  function automatic rxcv_fmt_s fmt_of(input logic [15:0] c, input logic [1:0] port);
    rxcv_fmt_s  f;
    logic [1:0] mode;
    logic       p3;
    logic       st;
    // default walk: header through last payload octet, HEC kept, no status
    f.first = `RXCV_IDX_HDR;
    f.last  = `RXCV_IDX_LAST;
    f.skip  = 1'b0;
    f.app   = 1'b0;
    // the 2-bit length code of this port
    mode  = c[{port, 1'b0} +: 2];                          // R12 R13
    // status handling exists on port 3 only
    p3    = (port == `RXCV_PORT3);
    st    = c[`RXCV_B_STAT_EN] && p3;
    // header-only output overrides whatever length port 3 is set to
    if (c[`RXCV_B_HDR_ONLY] && p3) begin
      f.last = `RXCV_IDX_HDR_END;                          // R6
      f.app  = 1'b1;                                       // R6
    end else begin
      case (mode)
        `RXCV_FMT_48: f.first = `RXCV_IDX_PAY;
        `RXCV_FMT_52: f.skip  = 1'b1;
        `RXCV_FMT_53: begin
          f.skip = st;                                     // R4
          f.app  = st;                                     // R4
        end
        default:      f.first = `RXCV_IDX_PLCP;
      endcase
    end
    return f;
  endfunction

  // octet source: PLCP overhead from the descriptor, header with correction, else buffer
  function automatic logic [7:0] octet_of(input logic [5:0] idx, input logic [7:0] mb, input rxcv_cell_s c);
    logic [7:0] o;
    logic [5:0] hoff;
    o    = mb;
    hoff = idx - `RXCV_IDX_HDR;
    // overhead octets are never buffered: they come from the cell descriptor
    // correction flips one stored header bit on its way out, the buffer keeps the raw octet
    if (idx < `RXCV_IDX_HDR) begin
      o = c.plcp[(5'd24 - {idx[1:0], 3'h0}) +: 8];
    end else if (idx <= `RXCV_IDX_HDR_END && c.corr && hoff[1:0] == c.cpos[4:3]) begin
      o = mb ^ (8'h01 << c.cpos[2:0]);                     // R10
    end
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register slave
  logic [15:0] ctrl;
  logic [15:0] stat_word;
  rxcv_st_s    q;
  rxcv_st_s    n;
  logic        we;
  logic [6:0]  waddr;
  logic [7:0]  mem_q;
  logic [7:0]  mem [0:127];

  // status readback: latched disable, write side busy, pending cell, sequencer state
  assign stat_word = {10'h000,
                      q.rst,      // sequencer state
                      q.pend.v,   // cell waiting for the sequencer
                      q.in_act,   // cell being written
                      q.wbank,    // bank taking the next cell
                      q.rx_off};  // disable as latched at the last start of cell

  rxcv_regs u_regs (
    .clk       (clk),
    .srst      (srst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .stat_in   (stat_word),
    .ctrl      (ctrl),
    .reg_rdata (reg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // two cell banks so one cell can arrive while the previous one drains
  // combinational read keeps the octet aligned with the index flop that selects it
  assign mem_q = mem[{q.rbank, q.ridx}];

  // write port only; no reset, a bank is always rewritten before it is read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= cell_in_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: output sequencer first, so a freed slot is seen by the writer
  always_comb begin
    logic       drop;
    logic       hec_bad;
    logic       fix;
    logic       start_ok;
    logic [5:0] nidx;
    logic       crc_bad;
    logic       len_bad;
    logic       busy_rd;
    logic       lost;
    drop     = 1'b0;
    hec_bad  = 1'b0;
    fix      = 1'b0;
    start_ok = 1'b0;
    nidx     = 6'h00;
    crc_bad  = 1'b0;
    len_bad  = 1'b0;
    busy_rd  = 1'b0;
    lost     = 1'b0;
    n         = q;
    n.ov      = 1'b0;
    n.fpin    = 1'b0;
    n.hec_evt = 1'b0;
    n.crc_evt = 1'b0;
    n.len_evt = 1'b0;
    we        = 1'b0;
    waddr     = {q.wbank, q.widx};

    // output sequencer; a full FIFO stalls it, but an octet registered just before full rises still appears in the first full cycle
    case (q.rst)
      RD_IDLE: begin
        if (q.pend.v) begin
          n.pend.v = 1'b0;
          // receiver switched off since this cell arrived: drop it unsent
          if (!q.rx_off) begin                             // R2
            n.cur   = q.pend;
            n.rbank = ~q.wbank;
            n.fmt   = fmt_of(ctrl, q.pend.port);           // R15
            n.ridx  = n.fmt.first;
            n.first = 1'b1;
            n.rst   = RD_DATA;
          end
        end
      end
      RD_DATA: begin
        if (!fifo_full) begin
          n.ov    = 1'b1;
          n.od    = octet_of(q.ridx, mem_q, q.cur);
          n.oport = q.cur.port;
          n.first = 1'b0;
          n.fpin  = ctrl[`RXCV_B_SOC_SEL] && q.first;      // R1
          nidx    = q.ridx + 6'h01;
          // formats without HEC step over its slot in the buffer
          if (q.fmt.skip && nidx == `RXCV_IDX_HEC) begin
            nidx = `RXCV_IDX_PAY;                          // R4
          end
          n.ridx = nidx;
          if (q.ridx == q.fmt.last) begin
            n.rst = q.fmt.app ? RD_STAT : RD_IDLE;         // R4 R6
          end
        end
      end
      // status octet closes a port 3 cell in status or header-only mode
      RD_STAT: begin
        if (!fifo_full) begin
          n.ov    = 1'b1;
          n.od    = {4'h0, q.cur.corr, q.cur.hec, q.cur.len, q.cur.crc};
          n.oport = q.cur.port;
          n.rst   = RD_IDLE;
        end
      end
      default: n.rst = RD_IDLE;
    endcase

    // cell writer; the disable bit is sampled only on a start of cell
    // a start while disabled leaves the writer idle, so the rest of that cell is ignored
    if (cell_in_valid) begin
      if (cell_in_soc) begin
        n.rx_off = ctrl[`RXCV_B_RX_DIS];                   // R3
        start_ok = !ctrl[`RXCV_B_RX_DIS];                  // R2
        n.in_act = start_ok;
        n.widx   = `RXCV_IDX_HDR + 6'h01;
        waddr    = {q.wbank, `RXCV_IDX_HDR};
        we       = start_ok;
      end else if (q.in_act) begin
        we     = 1'b1;
        n.widx = q.widx + 6'h01;
      end
    end

    // end of cell: count every error, then gate discards by the disables
    if (cell_in_valid && cell_in_eoc && q.in_act && !cell_in_soc) begin
      n.in_act  = 1'b0;
      n.hec_evt = hec_err;                                 // R10
      n.crc_evt = crc_err;                                 // R7
      n.len_evt = len_err;                                 // R8
      // a corrected header no longer counts as bad for the discard decision
      fix       = hec_err && hec_single && ctrl[`RXCV_B_HEC_COR];                // R10
      // the HEC check disable is ignored in UTOPIA mode
      hec_bad   = hec_err && !fix && !(ctrl[`RXCV_B_HEC_DIS] && !utopia_mode);  // R9
      // global and per-port disables each release a check
      crc_bad   = crc_err && !ctrl[`RXCV_B_CRC_DIS] && !port_crc_dis[cell_port];  // R7 R14
      len_bad   = len_err && !ctrl[`RXCV_B_LEN_DIS] && !port_len_dis[cell_port];  // R8 R14
      drop      = hec_bad || crc_bad || len_bad;
      // the other bank still drains: flipping banks now would let the next cell overwrite it
      busy_rd   = (q.rst != RD_IDLE) && (q.rbank == ~q.wbank) && (n.rst != RD_IDLE);
      lost      = !drop && (n.pend.v || busy_rd);
      // write error only in that pin mode, so the start marker mode never gets a pulse without an octet
      if (lost && !ctrl[`RXCV_B_SOC_SEL]) begin
        n.fpin = 1'b1;                                     // R1
      end
      if (!drop && !lost) begin
        n.pend.v    = 1'b1;
        n.pend.port = cell_port;
        n.pend.hec  = hec_err;
        n.pend.crc  = crc_err;
        n.pend.len  = len_err;
        n.pend.corr = fix;
        n.pend.cpos = hec_bitpos;
        n.pend.plcp = plcp_oh;
        n.wbank     = ~q.wbank;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset leaves the receiver enabled with nothing buffered
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state flops
  // one shared bus carries all four ports, fifo_port names the destination
  assign fifo_valid               = q.ov;
  assign fifo_data                = q.od;
  assign fifo_port                = q.oport;
  assign fifo_control_output_pins = q.fpin;
  assign hec_err_evt              = q.hec_evt;
  assign crc_err_evt              = q.crc_evt;
  assign len_err_evt              = q.len_evt;

endmodule // rxcv_top
`default_nettype wire

// ---- test/rxcv_top_monitor.sv ----
// checker of readback, error events, stall and marker pin
`timescale 1ns/100ps
`default_nettype none
`include "rxcv_defines.svh"
module rxcv_mon (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        cell_in_valid,
  input wire logic        cell_in_eoc,
  input wire logic        hec_err,
  input wire logic        crc_err,
  input wire logic        len_err,
  input wire logic        fifo_full,
  input wire logic        fifo_valid,
  input wire logic        fifo_control_output_pins,
  input wire logic        hec_err_evt,
  input wire logic        crc_err_evt,
  input wire logic        len_err_evt
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [15:0] ctrl_m;
  ////////////////////////////////////////
  // shadow control word, built from bus writes only
  always_ff @(posedge clk) begin
    if (srst) ctrl_m <= `RXCV_CTRL_RST;
    else if (reg_wr && reg_addr == `RXCV_CTRL_OFS) ctrl_m <= reg_wdata;
  end
  rd_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data off slot");
  rd_ctrl_a: assert property (
    $past(reg_rd && reg_addr == `RXCV_CTRL_OFS) |-> reg_rdata == $past(ctrl_m)) else $error("bad readback");
  rd_unmap_a: assert property (
    $past(reg_rd && reg_addr != `RXCV_CTRL_OFS && reg_addr != `RXCV_STAT_OFS) |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // two full cycles leave no room for a registered octet
  full_stall_a: assert property (
    fifo_full [*2] |=> !fifo_valid) else $error("octet during stall");
  hec_evt_a: assert property (
    hec_err_evt |-> $past(cell_in_valid && cell_in_eoc && hec_err)) else $error("stray hec event");
  crc_evt_a: assert property (
    crc_err_evt |-> $past(cell_in_valid && cell_in_eoc && crc_err)) else $error("stray crc event");
  len_evt_a: assert property (
    len_err_evt |-> $past(cell_in_valid && cell_in_eoc && len_err)) else $error("stray len event");
  soc_pin_a: assert property (
    $past(ctrl_m[`RXCV_B_SOC_SEL]) && fifo_control_output_pins |-> fifo_valid) else $error("marker without octet");
endmodule // rxcv_mon
bind rxcv_top rxcv_mon i_rxcv_mon (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .cell_in_valid, .cell_in_eoc, .hec_err, .crc_err, .len_err, .fifo_full, .fifo_valid,
  .fifo_control_output_pins, .hec_err_evt, .crc_err_evt, .len_err_evt);
`default_nettype wire

// ---- test/rxcv_sink.sv ----
// model of the system logic draining the cell output port
`timescale 1ns/100ps
`default_nettype none
module rxcv_sink (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       fifo_valid,
  input  wire logic [7:0] fifo_data,
  input  wire logic       pin,
  output logic            fifo_full,
  output logic      [7:0] cnt,
  output logic      [7:0] first,
  output logic      [7:0] last,
  output logic      [7:0] pins
);
  logic [2:0] ph = 3'h0;
  // full two cycles of five, so every cell is stalled a few times
  assign fifo_full = (ph >= 3'h3);
  // counts octets and marker pulses, keeps first and last octet
  always @(posedge clk) begin
    ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
    if (clr) begin
      {cnt, first, last, pins} <= 32'h0;
    end else begin
      pins <= pins + {7'h0, pin};
      if (fifo_valid) begin
        cnt <= cnt + 8'h01;
        last <= fifo_data;
        if (cnt == 8'h00) first <= fifo_data;
      end
    end
  end
endmodule // rxcv_sink
`default_nettype wire

// ---- test/rx_cell_validation_output_ctrl_tb_top.sv ----
// self-checking bench of the cell validation block
`timescale 1ns/100ps
`default_nettype none
`include "rxcv_defines.svh"
module rx_cell_validation_output_ctrl_tb_top;
  logic        clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, clr = 1'h0;
  logic        cell_in_valid = 1'h0, cell_in_soc = 1'h0, cell_in_eoc = 1'h0;
  logic        hec_err = 1'h0, crc_err = 1'h0, len_err = 1'h0, utopia_mode = 1'h0;
  logic        hsing = 1'h1;
  logic [3:0]  pdis = 4'h0;
  logic [7:0]  reg_addr = 8'h00, cell_in_data = 8'h00, s_cnt, s_first, s_last, s_pins, fifo_data;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [1:0]  cell_port = 2'h0, fifo_port;
  logic [2:0]  evs;
  logic        fifo_valid, fifo_full, pin, hec_err_evt, crc_err_evt, len_err_evt;
  int          failures = 0, compares = 0, n, k, ncell = 1;
  // ctrl, port, {utopia,hec,crc,len}, octets, first, last
  logic [45:0] rows [16] = '{
    {16'h0000, 2'h0, 4'h0, 8'h30, 8'h15, 8'h44}, {16'h0004, 2'h1, 4'h0, 8'h34, 8'h10, 8'h44},
    {16'h0020, 2'h2, 4'h0, 8'h35, 8'h10, 8'h44}, {16'h00C0, 2'h3, 4'h0, 8'h39, 8'hC1, 8'h44},
    {16'h0003, 2'h0, 4'h0, 8'h39, 8'hC1, 8'h44}, {16'h2880, 2'h3, 4'h2, 8'h35, 8'h10, 8'h01},
    {16'h1000, 2'h3, 4'h0, 8'h05, 8'h10, 8'h00}, {16'h0000, 2'h0, 4'h2, 8'h00, 8'h00, 8'h00},
    {16'h0800, 2'h0, 4'h2, 8'h30, 8'h15, 8'h44}, {16'h0400, 2'h1, 4'h1, 8'h30, 8'h15, 8'h44},
    {16'h0200, 2'h2, 4'h4, 8'h30, 8'h15, 8'h44}, {16'h0200, 2'h2, 4'hC, 8'h00, 8'h00, 8'h00},
    {16'h0101, 2'h0, 4'h4, 8'h34, 8'h11, 8'h44}, {16'h8004, 2'h1, 4'h0, 8'h34, 8'h10, 8'h44},
    {16'h0220, 2'h2, 4'h4, 8'h35, 8'h10, 8'h44}, {16'h2D80, 2'h3, 4'h7, 8'h35, 8'h11, 8'h0F}};
  always #2 clk = ~clk;
  rxcv_top i_rxcv_top (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cell_in_valid,
    .cell_in_soc, .cell_in_eoc, .cell_in_data, .cell_port, .hec_err, .hec_single(hsing), .hec_bitpos(5'h00),
    .crc_err, .len_err, .plcp_oh(32'hC1C2C3C4), .utopia_mode, .port_crc_dis(pdis), .port_len_dis(pdis),
    .fifo_full, .fifo_valid, .fifo_data, .fifo_port, .fifo_control_output_pins(pin), .hec_err_evt,
    .crc_err_evt, .len_err_evt);
  rxcv_sink i_rxcv_sink (.clk, .clr, .fifo_valid, .fifo_data, .pin, .fifo_full, .cnt(s_cnt),
    .first(s_first), .last(s_last), .pins(s_pins));
  ////////////////////////////////////////
  // sticky error events since the last clear
  always @(posedge clk) evs <= clr ? 3'h0 : evs | {hec_err_evt, crc_err_evt, len_err_evt};
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // ncell back-to-back 53-octet cells; check inputs are held over the whole run
  task automatic run(input logic [1:0] p, input logic [3:0] e, input logic [7:0] c);
    @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    for (int i = 0; i < 53 * ncell; i++) begin
      @(posedge clk);
      cell_in_valid <= 1'h1;
      cell_in_soc <= (i % 53 == 0);
      cell_in_eoc <= (i % 53 == 52);
      cell_in_data <= 8'(i % 53 + 16);
      cell_port <= p;
      {utopia_mode, hec_err, crc_err, len_err} <= e;
    end
    @(posedge clk);
    cell_in_valid <= 1'h0;
    cell_in_eoc <= 1'h0;
    for (k = 0; k < 300 && s_cnt !== c; k++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // table of formats and gating, then receiver switching and registers
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    for (n = 0; n < 16; n++) begin
      wr(`RXCV_CTRL_OFS, rows[n][45:30]);
      run(rows[n][29:28], rows[n][27:24], rows[n][23:16]);
      chk({8'h00, s_cnt}, {8'h00, rows[n][23:16]});
      chk({s_first, s_last}, rows[n][15:0]);
      chk({8'h00, s_pins}, {15'h0, rows[n][45] && rows[n][23:16] != 8'h00});
      chk({13'h0, evs}, {13'h0, rows[n][26:24]});
      $display("test %0d done", n);
    end
    wr(`RXCV_CTRL_OFS, 16'h4000);
    run(2'h0, 4'h2, 8'h00);
    chk({5'h0, s_cnt, evs}, 16'h0000);
    wr(`RXCV_CTRL_OFS, 16'h0000);
    fork
      run(2'h0, 4'h0, 8'h30);
      begin
        repeat (20) @(posedge clk);
        wr(`RXCV_CTRL_OFS, 16'h4000);
      end
    join
    chk({8'h00, s_cnt}, 16'h0030);
    run(2'h0, 4'h0, 8'h00);
    chk({8'h00, s_cnt}, 16'h0000);
    $display("test rx disable done");
    // per-port disables release a check even with the global bits clear
    pdis <= 4'h2;
    wr(`RXCV_CTRL_OFS, 16'h0000);
    run(2'h1, 4'h3, 8'h30);
    chk({8'h00, s_cnt}, 16'h0030);
    run(2'h0, 4'h3, 8'h00);
    chk({8'h00, s_cnt}, 16'h0000);
    // a multi-bit header error is never corrected, so the cell is dropped
    hsing <= 1'h0;
    wr(`RXCV_CTRL_OFS, 16'h0101);
    run(2'h0, 4'h4, 8'h00);
    chk({5'h0, s_cnt, evs}, 16'h0004);
    hsing <= 1'h1;
    // second cell of a back-to-back pair finds both banks busy and is lost
    wr(`RXCV_CTRL_OFS, 16'h0000);
    ncell = 2;
    run(2'h0, 4'h0, 8'h30);
    ncell = 1;
    chk({s_cnt, s_pins}, 16'h3001);
    $display("test port disables and write error done");
    wr(`RXCV_CTRL_OFS, 16'hA5C3);
    rd(`RXCV_CTRL_OFS, 16'hA5C3);
    rd(8'h40, 16'h0000);
    @(posedge clk);
    srst <= 1'h1;
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    rd(`RXCV_CTRL_OFS, 16'h0000);
    $display("test registers done");
    report_and_stop;
  end
  // about twenty cells of at most 400 cycles, with margin
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
endmodule // rx_cell_validation_output_ctrl_tb_top
`default_nettype wire
